// File: hdl/ffsap_pkg.sv
// Shared constants and types for the flash fault status and protection block
package ffsap_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] FLASH_CONFIG_OFF = 16'h3024;
  localparam logic [15:0] MAIN_STATUS_OFF = 16'h3025;
  localparam logic [15:0] FAULT_STATUS_OFF = 16'h3027;
  localparam logic [15:0] RANGE_PROT_OFF = 16'h3028;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int SINGLE_FAULT_BIT = 0;
  localparam int DOUBLE_FAULT_BIT = 1;
  localparam int IGNORE_SINGLE_BIT = 0;
  localparam int PROT_VIOL_BIT = 4;
  localparam logic [7:0] FAULT_STATUS_MASK = 8'h03;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // ****************************************
  // Flash address space and range spans
  // ****************************************
  localparam logic [15:0] FLASH_BASE = 16'h8000;
  localparam logic [16:0] FLASH_END_EXCL = 17'h10000;
  localparam logic [15:0] RANGE_UNIT = 16'h0400;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_READY = 2'b10
  } ffsap_state_t;

  typedef struct packed {
    logic read;
    logic single;
    logic dbl;
    logic busy;
  } ffsap_rd_evt_t;

  typedef struct packed {
    logic sense;
    logic fixed_one;
    logic hdis;
    logic [1:0] hsize;
    logic ldis;
    logic [1:0] lsize;
  } ffsap_prot_t;

  // Span of a protection range for a two-bit size code
  function automatic logic [15:0] range_span(input logic [1:0] code);
    range_span = RANGE_UNIT << code;
  endfunction : range_span

endpackage : ffsap_pkg

// File: hdl/ffsap_range_check.sv
// Address classification against the flash protection ranges
`timescale 1ns/1ps
`default_nettype none
module ffsap_range_check import ffsap_pkg::*; (
  // Protection setting
  input wire ffsap_prot_t prot_i,
  // Target of a program or erase
  input wire logic [15:0] addr_i,
  // Verdicts
  output logic addr_protected_o,
  output logic block_protected_o
);

  logic [16:0] hi_start;
  logic [16:0] lo_end;
  logic in_hi;
  logic in_lo;
  logic in_flash;
  logic cover_all;

  always_comb begin
    hi_start = FLASH_END_EXCL - {1'b0, range_span(prot_i.hsize)};
    lo_end = {1'b0, FLASH_BASE} + {1'b0, range_span(prot_i.lsize)};
    in_flash = addr_i >= FLASH_BASE;
    in_hi = !prot_i.hdis && ({1'b0, addr_i} >= hi_start);
    in_lo = !prot_i.ldis && in_flash && ({1'b0, addr_i} < lo_end);
    // With sense clear, only two enabled ranges that meet can leave no protected sector
    cover_all = !prot_i.hdis && !prot_i.ldis && (hi_start <= lo_end);
    if (prot_i.sense) begin
      addr_protected_o = in_hi || in_lo;
      block_protected_o = !prot_i.hdis || !prot_i.ldis;
    end else begin
      addr_protected_o = in_flash && !(in_hi || in_lo);
      block_protected_o = !cover_all;
    end
  end

endmodule : ffsap_range_check
`default_nettype wire

// File: hdl/ffsap_top.sv
// Flash ECC fault status and range protection registers
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ffsap_top import ffsap_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Flash array read outcome
  input wire ffsap_rd_evt_t array_rd_i,
  // Reset sequence load of the protection byte
  input wire logic nv_load_i,
  input wire logic [7:0] nv_prot_byte_i,
  // Program or erase request
  input wire logic pe_req_i,
  input wire logic pe_block_erase_i,
  input wire logic [15:0] pe_addr_i,
  output logic pe_grant_o,
  output logic pe_deny_o,
  // Status
  output logic cmd_launch_ok_o,
  output logic prot_ready_o
);

  // ****************************************
  // Storage
  // ****************************************
  ffsap_state_t state;
  ffsap_rd_evt_t rd_stage;
  ffsap_prot_t prot;
  ffsap_prot_t next_prot;
  logic single_fault_flag;
  logic double_fault_flag;
  logic ignore_single_fault;
  logic protection_violation_flag;
  logic addr_protected;
  logic block_protected;
  logic pe_refuse;
  logic prot_accept;

  // ****************************************
  // Address decode
  // ****************************************
  logic wr_fault;
  logic wr_prot;
  logic wr_cfg;
  logic wr_stat;

  always_comb begin
    wr_fault = 1'b0;
    wr_prot = 1'b0;
    wr_cfg = 1'b0;
    wr_stat = 1'b0;
    if (reg_addr_i == FAULT_STATUS_OFF) begin
      wr_fault = reg_wr_i;
    end else if (reg_addr_i == RANGE_PROT_OFF) begin
      wr_prot = reg_wr_i;
    end else if (reg_addr_i == FLASH_CONFIG_OFF) begin
      wr_cfg = reg_wr_i;
    end else if (reg_addr_i == MAIN_STATUS_OFF) begin
      wr_stat = reg_wr_i;
    end
  end

  // ****************************************
  // Reset sequence
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_LOAD;
    end else begin
      case (state)
        ST_LOAD: begin
          if (nv_load_i) begin
            state <= ST_READY;
          end
        end
        ST_READY: begin
          state <= ST_READY;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  assign prot_ready_o = (state == ST_READY);

  // ****************************************
  // ECC fault capture
  // ****************************************
  // The read outcome is staged first so the flags land one clock later
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_stage <= '0;
    end else begin
      rd_stage <= array_rd_i;
    end
  end

  logic set_double;
  logic set_single;

  always_comb begin
    set_double = 1'b0;
    set_single = 1'b0;
    if (rd_stage.read) begin
      if (rd_stage.busy) begin
        set_double = 1'b1;
        set_single = 1'b1;
      end else if (rd_stage.dbl) begin
        set_double = 1'b1;
      end else if (rd_stage.single && !ignore_single_fault) begin
        set_single = 1'b1;
      end
    end
  end

  // A fault in the clearing cycle is kept: set wins over clear
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      double_fault_flag <= 1'b0;
    end else if (set_double) begin
      double_fault_flag <= 1'b1;
    end else if (wr_fault && reg_wdata_i[DOUBLE_FAULT_BIT]) begin
      double_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      single_fault_flag <= 1'b0;
    end else if (set_single) begin
      single_fault_flag <= 1'b1;
    end else if (wr_fault && reg_wdata_i[SINGLE_FAULT_BIT]) begin
      single_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ignore_single_fault <= CONFIG_RESET[IGNORE_SINGLE_BIT];
    end else if (wr_cfg) begin
      ignore_single_fault <= reg_wdata_i[IGNORE_SINGLE_BIT];
    end
  end

  // ****************************************
  // Protection register
  // ****************************************
  // True when a range keeps or widens its coverage
  function automatic logic range_grows(input logic odis, input logic [1:0] osize,
                                       input logic ndis, input logic [1:0] nsize);
    range_grows = odis || (!ndis && (nsize >= osize));
  endfunction : range_grows

  always_comb begin
    next_prot = ffsap_prot_t'(reg_wdata_i);
    next_prot.fixed_one = 1'b1;
    next_prot.hsize = prot.hdis ? next_prot.hsize : prot.hsize;
    next_prot.lsize = prot.ldis ? next_prot.lsize : prot.lsize;
    // Flipping the sense can remove coverage, so it is never taken
    if (next_prot.sense != prot.sense) begin
      prot_accept = 1'b0;
    end else if (prot.sense) begin
      prot_accept = range_grows(prot.hdis, prot.hsize, next_prot.hdis, next_prot.hsize) &&
                    range_grows(prot.ldis, prot.lsize, next_prot.ldis, next_prot.lsize);
    end else begin
      prot_accept = range_grows(next_prot.hdis, next_prot.hsize, prot.hdis, prot.hsize) &&
                    range_grows(next_prot.ldis, next_prot.lsize, prot.ldis, prot.lsize);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prot <= ffsap_prot_t'(PROT_RESET);
    end else if (state == ST_LOAD) begin
      if (nv_load_i) begin
        prot <= ffsap_prot_t'(nv_prot_byte_i | PROT_RESET & 8'h40);
      end
    end else if (wr_prot && prot_accept) begin
      prot <= next_prot;
    end
  end

  ffsap_range_check u_range_check (
    .prot_i(prot),
    .addr_i(pe_addr_i),
    .addr_protected_o(addr_protected),
    .block_protected_o(block_protected)
  );

  // ****************************************
  // Program and erase gating
  // ****************************************
  always_comb begin
    pe_refuse = pe_block_erase_i ? block_protected : addr_protected;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      protection_violation_flag <= 1'b0;
    end else if (pe_req_i && prot_ready_o && pe_refuse) begin
      protection_violation_flag <= 1'b1;
    end else if (wr_stat && reg_wdata_i[PROT_VIOL_BIT]) begin
      protection_violation_flag <= 1'b0;
    end
  end

  // A pending violation blocks every launch until software clears it
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pe_grant_o <= 1'b0;
      pe_deny_o <= 1'b0;
    end else begin
      pe_grant_o <= pe_req_i && prot_ready_o && !protection_violation_flag && !pe_refuse;
      pe_deny_o <= pe_req_i && (!prot_ready_o || protection_violation_flag || pe_refuse);
    end
  end

  assign cmd_launch_ok_o = prot_ready_o && !protection_violation_flag;

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == FAULT_STATUS_OFF) begin
      reg_rdata_o <= {6'h00, double_fault_flag, single_fault_flag} & FAULT_STATUS_MASK;
    end else if (reg_addr_i == RANGE_PROT_OFF) begin
      reg_rdata_o <= prot | 8'h40;
    end else if (reg_addr_i == FLASH_CONFIG_OFF) begin
      reg_rdata_o <= {7'h00, ignore_single_fault};
    end else if (reg_addr_i == MAIN_STATUS_OFF) begin
      reg_rdata_o <= {3'h0, protection_violation_flag, 4'h0};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_dbl_read;
    array_rd_i.read && array_rd_i.dbl && !array_rd_i.busy;
  endsequence

  sequence s_busy_read;
    array_rd_i.read && array_rd_i.busy;
  endsequence

  sequence s_bad_request;
    pe_req_i && prot_ready_o && !protection_violation_flag && pe_refuse;
  endsequence

  sequence s_flag_and_deny;
    pe_deny_o && protection_violation_flag && !pe_grant_o;
  endsequence

  chk_double_delay: assert property (s_dbl_read |-> ##2 double_fault_flag)
    else $error("double fault flag not set two cycles after read");

  chk_collision_both: assert property (s_busy_read |-> ##2 (single_fault_flag && double_fault_flag))
    else $error("collision did not raise both flags");

  chk_single_exclusive: assert property (rd_stage.read && rd_stage.dbl && !rd_stage.busy
    && !single_fault_flag |=> !single_fault_flag)
    else $error("double fault also raised single fault");

  chk_single_ignored: assert property (rd_stage.read && rd_stage.single && !rd_stage.dbl && !rd_stage.busy
    && ignore_single_fault && !single_fault_flag |=> !single_fault_flag)
    else $error("ignored single fault was recorded");

  chk_double_w1c: assert property (wr_fault && reg_wdata_i[DOUBLE_FAULT_BIT] && !set_double
    |=> !double_fault_flag)
    else $error("double fault flag survived write one");

  chk_single_w0_keep: assert property (wr_fault && !reg_wdata_i[SINGLE_FAULT_BIT] && single_fault_flag
    |=> single_fault_flag)
    else $error("single fault flag lost on write zero");

  chk_reserved_zero: assert property (reg_rd_i && reg_addr_i == FAULT_STATUS_OFF
    |=> reg_rdata_o[7:2] == 6'h00)
    else $error("reserved fault status bits not zero");

  chk_fixed_one: assert property (reg_rd_i && reg_addr_i == RANGE_PROT_OFF |=> reg_rdata_o[6])
    else $error("protection bit 6 not one");

  chk_sense_kept: assert property (wr_prot && prot_ready_o |=> prot.sense == $past(prot.sense))
    else $error("protection sense changed by software");

  chk_hsize_locked: assert property (wr_prot && prot_ready_o && !prot.hdis
    |=> prot.hsize == $past(prot.hsize))
    else $error("high size changed while range enabled");

  chk_lsize_locked: assert property (wr_prot && prot_ready_o && !prot.ldis
    |=> prot.lsize == $past(prot.lsize))
    else $error("low size changed while range enabled");

  chk_nv_load: assert property (state == ST_LOAD && nv_load_i
    |=> prot == ffsap_prot_t'($past(nv_prot_byte_i) | 8'h40))
    else $error("protection not loaded from nonvolatile byte");

  chk_viol_set: assert property (s_bad_request |=> s_flag_and_deny)
    else $error("protected request did not raise violation");

  chk_viol_blocks: assert property (pe_req_i && protection_violation_flag |=> pe_deny_o && !pe_grant_o)
    else $error("request granted while violation pending");

endmodule : ffsap_top
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking testbench for the flash fault status and protection block
`timescale 1ns/1ps
`default_nettype none
module tb_top import ffsap_pkg::*; ;

  // ****************************************
  // Signals
  // ****************************************
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  ffsap_rd_evt_t array_rd = '0;
  logic nv_load = 1'b0;
  logic [7:0] nv_byte = 8'h00;
  logic pe_req = 1'b0;
  logic pe_blk = 1'b0;
  logic [15:0] pe_addr = 16'h0000;
  logic pe_grant;
  logic pe_deny;
  logic launch_ok;
  logic prot_ready;
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h4725417B;

  always #50 ref_clk_i = ~ref_clk_i;

  ffsap_top dut (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata),
    .array_rd_i(array_rd),
    .nv_load_i(nv_load),
    .nv_prot_byte_i(nv_byte),
    .pe_req_i(pe_req),
    .pe_block_erase_i(pe_blk),
    .pe_addr_i(pe_addr),
    .pe_grant_o(pe_grant),
    .pe_deny_o(pe_deny),
    .cmd_launch_ok_o(launch_ok),
    .prot_ready_o(prot_ready)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr_next

  // Collision marks both flags; otherwise at most one flag per fault event
  function automatic logic [7:0] exp_flags(input logic s, input logic d, input logic b, input logic ign);
    if (b) begin
      exp_flags = 8'h03;
    end else if (d) begin
      exp_flags = 8'h02;
    end else if (s && !ign) begin
      exp_flags = 8'h01;
    end else begin
      exp_flags = 8'h00;
    end
  endfunction : exp_flags

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic reg_check(input logic [15:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd <= 1'b0;
    @(negedge ref_clk_i);
    check(name, reg_rdata, exp);
  endtask : reg_check

  task automatic fault_event(input logic s, input logic d, input logic b);
    @(posedge ref_clk_i);
    array_rd <= '{read: 1'b1, single: s, dbl: d, busy: b};
    @(posedge ref_clk_i);
    array_rd <= '0;
  endtask : fault_event

  task automatic pe_try(input logic [15:0] a, input logic blk, input logic grant);
    @(posedge ref_clk_i);
    pe_req <= 1'b1;
    pe_addr <= a;
    pe_blk <= blk;
    @(posedge ref_clk_i);
    pe_req <= 1'b0;
    @(negedge ref_clk_i);
    check("pe_grant", {7'h00, pe_grant}, {7'h00, grant});
    check("pe_deny", {7'h00, pe_deny}, {7'h00, !grant});
  endtask : pe_try

  // ****************************************
  // Watchdog
  // ****************************************
  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    check("prot_ready", {7'h00, prot_ready}, 8'h00);
    reg_write(RANGE_PROT_OFF, 8'h00);
    reg_check(RANGE_PROT_OFF, PROT_RESET, "prot_before_load");
    pe_try(16'h9000, 1'b0, 1'b0);
    reg_check(16'h3030, 8'h00, "unmapped");
    // Load a byte with bit 6 clear; it must read back as one
    @(posedge ref_clk_i);
    nv_load <= 1'b1;
    nv_byte <= 8'h00;
    @(posedge ref_clk_i);
    nv_load <= 1'b0;
    @(negedge ref_clk_i);
    check("prot_ready", {7'h00, prot_ready}, 8'h01);
    reg_check(RANGE_PROT_OFF, 8'h40, "prot_loaded");
    // Sense 0, both ranges enabled at span 0x400: ends unprotected, middle protected
    check("launch_ok", {7'h00, launch_ok}, 8'h01);
    pe_try(16'h9000, 1'b0, 1'b0);
    reg_check(MAIN_STATUS_OFF, 8'h10, "viol_flag");
    check("launch_ok", {7'h00, launch_ok}, 8'h00);
    pe_try(16'hFC00, 1'b0, 1'b0);
    reg_write(MAIN_STATUS_OFF, 8'h00);
    reg_check(MAIN_STATUS_OFF, 8'h10, "viol_w0");
    reg_write(MAIN_STATUS_OFF, 8'h10);
    reg_check(MAIN_STATUS_OFF, 8'h00, "viol_w1c");
    pe_try(16'hFC00, 1'b0, 1'b1);
    // Top sector is unprotected, so the protection byte may be reprogrammed
    pe_try(16'hFF7C, 1'b0, 1'b1);
    pe_try(16'h83FF, 1'b0, 1'b1);
    pe_try(16'h8400, 1'b0, 1'b0);
    reg_write(MAIN_STATUS_OFF, 8'h10);
    pe_try(16'h8000, 1'b1, 1'b0);
    reg_write(MAIN_STATUS_OFF, 8'h10);
    // Protection writes: sense change refused, disabling a sense-0 range grows protection
    reg_write(RANGE_PROT_OFF, 8'hC0);
    reg_check(RANGE_PROT_OFF, 8'h40, "prot_sense");
    reg_write(RANGE_PROT_OFF, 8'h38);
    reg_check(RANGE_PROT_OFF, 8'h60, "prot_hsize_locked");
    reg_write(RANGE_PROT_OFF, 8'h78);
    reg_check(RANGE_PROT_OFF, 8'h78, "prot_hsize");
    reg_write(RANGE_PROT_OFF, 8'h5B);
    reg_check(RANGE_PROT_OFF, 8'h78, "prot_shrink");
    reg_write(RANGE_PROT_OFF, 8'h7F);
    reg_check(RANGE_PROT_OFF, 8'h7C, "prot_lsize_locked");
    reg_write(RANGE_PROT_OFF, 8'h7F);
    reg_check(RANGE_PROT_OFF, 8'h7F, "prot_lsize");
    pe_try(16'hFFFF, 1'b0, 1'b0);
    reg_write(MAIN_STATUS_OFF, 8'h10);
    pe_try(16'h1000, 1'b0, 1'b1);
    // Fault flags: collision, write-zero, single-bit clears, reserved bits
    fault_event(1'b0, 1'b0, 1'b1);
    reg_check(FAULT_STATUS_OFF, 8'h03, "collision");
    reg_write(FAULT_STATUS_OFF, 8'h00);
    reg_check(FAULT_STATUS_OFF, 8'h03, "fault_w0");
    reg_write(FAULT_STATUS_OFF, 8'h02);
    reg_check(FAULT_STATUS_OFF, 8'h01, "dbl_w1c");
    reg_write(FAULT_STATUS_OFF, 8'hFD);
    reg_check(FAULT_STATUS_OFF, 8'h00, "single_w1c");
    fault_event(1'b1, 1'b1, 1'b0);
    reg_check(FAULT_STATUS_OFF, 8'h02, "dbl_only");
    reg_write(FAULT_STATUS_OFF, 8'hFF);
    // Random fault events with the ignore bit toggled
    for (int i = 0; i < 32; i++) begin
      seed = lfsr_next(seed);
      reg_write(FLASH_CONFIG_OFF, {7'h00, seed[3]});
      fault_event(seed[0], seed[1], seed[2] & seed[4]);
      reg_check(FAULT_STATUS_OFF, exp_flags(seed[0], seed[1], seed[2] & seed[4], seed[3]), "fault_rand");
      reg_write(FAULT_STATUS_OFF, 8'h03);
      reg_check(FAULT_STATUS_OFF, 8'h00, "fault_clear");
    end
    // Mid-run reset, then a byte with the protected sense loads
    fault_event(1'b0, 1'b1, 1'b0);
    reg_check(FAULT_STATUS_OFF, 8'h02, "dbl_before_reset");
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(negedge ref_clk_i);
    check("prot_ready_rst", {7'h00, prot_ready}, 8'h00);
    check("launch_ok_rst", {7'h00, launch_ok}, 8'h00);
    reg_check(FAULT_STATUS_OFF, 8'h00, "fault_after_reset");
    reg_check(RANGE_PROT_OFF, PROT_RESET, "prot_after_reset");
    @(posedge ref_clk_i);
    nv_load <= 1'b1;
    nv_byte <= 8'h80;
    @(posedge ref_clk_i);
    nv_load <= 1'b0;
    reg_check(RANGE_PROT_OFF, 8'hC0, "prot_sense1");
    pe_try(16'h9000, 1'b0, 1'b1);
    pe_try(16'hFFFF, 1'b0, 1'b0);
    reg_write(MAIN_STATUS_OFF, 8'h10);
    pe_try(16'h8000, 1'b0, 1'b0);
    reg_write(MAIN_STATUS_OFF, 8'h10);
    pe_try(16'h9000, 1'b1, 1'b0);
    reg_write(MAIN_STATUS_OFF, 8'h10);
    // Disabling a protected range would shrink protection
    reg_write(RANGE_PROT_OFF, 8'hE4);
    reg_check(RANGE_PROT_OFF, 8'hC0, "prot_sense1_shrink");
    end_of_test();
  end

endmodule : tb_top
`default_nettype wire
